// ### inc/tppwm_pkg.sv
// ==========================================================
// constants of the three-phase pwm waveform core
package tppwm_pkg;
  // ========================================================
  // register offsets (word index on the plain register port)
  localparam logic [2:0] OFS_CONTROL_A  = 3'h0;
  localparam logic [2:0] OFS_CONTROL_B  = 3'h1;
  localparam logic [2:0] OFS_PERIOD     = 3'h2;
  localparam logic [2:0] OFS_COMPARE_U  = 3'h3;
  localparam logic [2:0] OFS_COMPARE_V  = 3'h4;
  localparam logic [2:0] OFS_COMPARE_W  = 3'h5;
  localparam logic [2:0] OFS_ARITH_CTRL = 3'h6;
  localparam logic [2:0] OFS_STATUS     = 3'h7;

  // ========================================================
  // field positions of pwm_control_a
  localparam int BIT_GEN_ENABLE   = 0; // waveform generation on
  localparam int BIT_SHAPE_SELECT = 1; // 0 sawtooth, 1 triangular
  localparam int BIT_LOWER_POL    = 4; // lower-phase polarity
  localparam int BIT_UPPER_POL    = 5; // upper-phase polarity
  localparam int BIT_DUTY_COMMON  = 6; // all phases from u compare
  // field positions of waveform_arith_control
  localparam int BIT_CALC_ENABLE  = 1; // arithmetic results accepted
  localparam int BIT_XFER_ENABLE  = 2; // results own compare regs
  localparam int BIT_XFER_INHIBIT = 4; // results kept off the pins
  // field positions of the status word
  localparam int BIT_STAT_DOWN    = 12; // carrier counting down
  localparam int BIT_STAT_ENABLED = 13; // generator running

  // ========================================================
  // reset values
  localparam logic [7:0]  RST_CONTROL_A  = 8'h00; // active low outputs
  localparam logic [2:0]  RST_CLOCK_SEL  = 3'h0;  // every mclk
  localparam logic [11:0] RST_PERIOD     = 12'h000;
  localparam logic [11:0] RST_COMPARE    = 12'h000;
  localparam logic [7:0]  RST_ARITH_CTRL = 8'h00;

  // ========================================================
  // carrier shapes
  typedef enum logic {
    SHAPE_SAWTOOTH,
    SHAPE_TRIANGLE
  } tppwm_shape_type;
endpackage

// ### logic/tppwm_core.sv
// Summary of operation
// RULE1 - mode bit picks triangular or sawtooth carrier
// RULE2 - sawtooth period equals period value ticks
// RULE3 - triangular period equals twice period value
// RULE4 - period and compares double-buffered, load per period
// RULE5 - arithmetic results become the phase compare values
// RULE6 - calc plus transfer enabled blocks software compare writes
// RULE7 - transfer inhibited: buffers filled, pins kept idle
// RULE8 - compare read returns buffered arithmetic result
// RULE9 - software compare writes drive the pwm duty
// RULE10 - written value reads back until next result
// RULE11 - outputs active low after reset
// RULE12 - one shared carrier for all three phases
// RULE13 - outside port data and control set to one
// RULE14 - carrier is 12-bit up/down counter on tick
// RULE15 - phase output from compare versus carrier magnitude
// RULE16 - mode 0 edge sawtooth, 1 center triangular
// RULE17 - upper and lower polarity bits independent
// RULE18 - buffers load at zero or triangular valley
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tppwm_core
  import tppwm_pkg::*;
#(
  parameter int CNT_W = 12                      // carrier width
) (
  input  wire logic             mclk,           // system clock 50 mhz
  input  wire logic             reset,          // sync reset, high
  input  wire logic [2:0]       reg_addr,       // register index
  input  wire logic [15:0]      reg_wdata,      // write data
  input  wire logic             reg_wr,         // write strobe
  input  wire logic             reg_rd,         // read strobe
  output logic      [15:0]      reg_rdata,      // read data, next cycle
  input  wire logic             arith_valid,    // result pulse
  input  wire logic [CNT_W-1:0] arith_u,        // result for u phase
  input  wire logic [CNT_W-1:0] arith_v,        // result for v phase
  input  wire logic [CNT_W-1:0] arith_w,        // result for w phase
  output logic                  pwm_u,          // upper u output
  output logic                  pwm_v,          // upper v output
  output logic                  pwm_w,          // upper w output
  output logic                  pwm_x,          // lower u output
  output logic                  pwm_y,          // lower v output
  output logic                  pwm_z           // lower w output
);

  // ========================================================
  // elaboration check
  // the carrier must hold a few steps and fit the 16-bit register
  // port; above 12 bits the status flags share bit positions with
  // the upper carrier bits, so status reads lose those carrier bits
  if (CNT_W < 4 || CNT_W > 16) begin : g_bad_width
    $error("carrier width must lie between 4 and 16");
  end

  // ========================================================
  // declarations
  logic [7:0]       pwm_control_a_ff;          // control a
  logic [2:0]       carrier_clock_select_ff;   // prescale exponent
  logic [7:0]       waveform_arith_control_ff; // arithmetic control
  logic [CNT_W-1:0] period_buf_ff;             // software period
  logic [CNT_W-1:0] period_act_ff;             // period in use
  logic [CNT_W-1:0] cmp_buf_ff [3];            // compare buffers
  logic [CNT_W-1:0] cmp_act_ff [3];            // compares in use
  logic [CNT_W-1:0] carrier_counter_ff;        // shared carrier
  logic [CNT_W-1:0] nxt_carrier_counter;       // next carrier
  logic             count_down_ff;             // triangle falling
  logic             nxt_count_down;            // next direction
  logic [6:0]       prescale_ff;               // tick divider
  logic             carrier_tick;              // one-cycle tick
  logic             period_start;              // start of period
  logic [2:0]       phase_on;                  // raw phase states
  logic             compare_lock;              // writes refused
  logic             pins_inhibit;              // results off pins
  logic             gen_enable;                // generator running
  tppwm_shape_type  carrier_shape_select;      // decoded shape
  logic [15:0]      nxt_rdata;                 // read mux
  logic [5:0]       nxt_pins;                  // next pin levels

  // ========================================================
  // decode helpers
  // software write strobe to one register
  function automatic logic wr_hit(input logic [2:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  // zero-extend a carrier-width value to the bus width
  function automatic logic [15:0] to_bus(input logic [CNT_W-1:0] v);
    logic [15:0] r;
    r = '0;
    r[CNT_W-1:0] = v;
    return r;
  endfunction

  assign gen_enable = pwm_control_a_ff[BIT_GEN_ENABLE];
  // mode bit selects the carrier shape
  assign carrier_shape_select = pwm_control_a_ff[BIT_SHAPE_SELECT] ?
                                SHAPE_TRIANGLE : SHAPE_SAWTOOTH; // RULE1 RULE16
  // arithmetic results own the compare registers
  assign compare_lock = waveform_arith_control_ff[BIT_CALC_ENABLE] &&
                        waveform_arith_control_ff[BIT_XFER_ENABLE]; // RULE6
  // results land in buffers but never reach the pins
  assign pins_inhibit = waveform_arith_control_ff[BIT_CALC_ENABLE] &&
                        waveform_arith_control_ff[BIT_XFER_INHIBIT]; // RULE7

  // ========================================================
  // control registers
  // control a, control b and arithmetic control
  // writes take effect on the edge that samples the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwm_control_a_ff          <= RST_CONTROL_A; // RULE11
      carrier_clock_select_ff   <= RST_CLOCK_SEL;
      waveform_arith_control_ff <= RST_ARITH_CTRL;
    end else begin
      if (wr_hit(OFS_CONTROL_A)) begin
        pwm_control_a_ff <= reg_wdata[7:0];
      end
      if (wr_hit(OFS_CONTROL_B)) begin
        carrier_clock_select_ff <= reg_wdata[2:0];
      end
      if (wr_hit(OFS_ARITH_CTRL)) begin
        waveform_arith_control_ff <= reg_wdata[7:0];
      end
    end
  end

  // ========================================================
  // period buffer
  // software side of the double-buffered period
  // the period index reads back this buffer, never the value in use
  always_ff @(posedge mclk) begin
    if (reset) begin
      period_buf_ff <= RST_PERIOD;
    end else if (wr_hit(OFS_PERIOD)) begin
      period_buf_ff <= reg_wdata[CNT_W-1:0]; // RULE4
    end
  end

  // ========================================================
  // compare buffers, one per phase
  // a locked software write is dropped without any error flag, so
  // firmware must read back to learn whether its value was taken
  generate
    for (genvar p = 0; p < 3; p++) begin : g_phase
      logic [CNT_W-1:0] result; // arithmetic result for this phase
      assign result = (p == 0) ? arith_u : (p == 1) ? arith_v : arith_w;

      // a new result wins over a software write in the same cycle
      always_ff @(posedge mclk) begin
        if (reset) begin
          cmp_buf_ff[p] <= RST_COMPARE;
        end else if (arith_valid &&
                     waveform_arith_control_ff[BIT_CALC_ENABLE]) begin
          cmp_buf_ff[p] <= result; // RULE5 RULE7 RULE8 RULE10
        end else if (wr_hit(OFS_COMPARE_U + 3'(p)) && !compare_lock) begin
          cmp_buf_ff[p] <= reg_wdata[CNT_W-1:0]; // RULE9 RULE10
        end
      end

      // active compare follows the buffer at each period start
      always_ff @(posedge mclk) begin
        if (reset) begin
          cmp_act_ff[p] <= RST_COMPARE;
        end else if (!gen_enable || period_start) begin
          cmp_act_ff[p] <= cmp_buf_ff[p]; // RULE4 RULE18
        end
      end

      // magnitude comparison against the shared carrier
      assign phase_on[p] = pwm_control_a_ff[BIT_DUTY_COMMON] ?
                           (carrier_counter_ff < cmp_act_ff[0]) :
                           (carrier_counter_ff < cmp_act_ff[p]); // RULE12 RULE15
    end
  endgenerate

  // ========================================================
  // carrier clock prescaler
  // tick once every 2**select mclk cycles
  // the divider restarts while the generator is off, so the first
  // carrier step after enable comes at a fixed offset from the enable
  always_ff @(posedge mclk) begin
    if (reset || !gen_enable) begin
      prescale_ff <= '0;
    end else begin
      prescale_ff <= prescale_ff + 7'h01;
    end
  end

  // tick when all low select bits of the divider are ones
  always_comb begin
    logic [6:0] mask;
    mask = 7'((8'h01 << carrier_clock_select_ff) - 8'h01);
    carrier_tick = gen_enable && ((prescale_ff & mask) == mask);
  end

  // ========================================================
  // carrier counter
  // up/down counting of the shared 12-bit carrier
  // a period of zero parks the carrier at zero and reloads the buffers
  // on every tick; the phases then sit fully on or fully off
  // changing the shape while running keeps the count and direction,
  // so the shape bit should only change while the generator is off
  always_comb begin
    nxt_carrier_counter = carrier_counter_ff;
    nxt_count_down      = count_down_ff;
    period_start        = 1'b0;
    case (carrier_shape_select)
      SHAPE_SAWTOOTH: begin
        // 0 .. period-1, then back to zero
        nxt_count_down = 1'b0;
        if (carrier_counter_ff + 1'b1 >= period_act_ff) begin
          nxt_carrier_counter = '0; // RULE2
          period_start        = 1'b1; // RULE18
        end else begin
          nxt_carrier_counter = carrier_counter_ff + 1'b1; // RULE14
        end
      end
      SHAPE_TRIANGLE: begin
        // 0 up to period, then down to the valley at zero
        if (period_act_ff == '0) begin
          nxt_carrier_counter = '0;
          nxt_count_down      = 1'b0;
          period_start        = 1'b1;
        end else if (!count_down_ff) begin
          nxt_carrier_counter = carrier_counter_ff + 1'b1; // RULE14
          if (carrier_counter_ff + 1'b1 >= period_act_ff) begin
            nxt_count_down = 1'b1; // RULE3
          end
        end else begin
          nxt_carrier_counter = carrier_counter_ff - 1'b1; // RULE14
          if (carrier_counter_ff == 1) begin
            nxt_count_down = 1'b0;
            period_start   = 1'b1; // RULE3 RULE18
          end
        end
      end
      default: begin
        nxt_carrier_counter = '0;
        nxt_count_down      = 1'b0;
      end
    endcase
    // only a carrier tick advances anything
    if (!carrier_tick) begin
      nxt_carrier_counter = carrier_counter_ff;
      nxt_count_down      = count_down_ff;
      period_start        = 1'b0;
    end
  end

  // carrier state, held at zero while the generator is off
  always_ff @(posedge mclk) begin
    if (reset || !gen_enable) begin
      carrier_counter_ff <= '0;
      count_down_ff      <= 1'b0;
    end else begin
      carrier_counter_ff <= nxt_carrier_counter;
      count_down_ff      <= nxt_count_down;
    end
  end

  // ========================================================
  // active period
  // new period takes effect only at the start of a period
  // while the generator is off the active copies follow the buffers,
  // so the first period after enable already uses the latest values
  always_ff @(posedge mclk) begin
    if (reset) begin
      period_act_ff <= RST_PERIOD;
    end else if (!gen_enable || period_start) begin
      period_act_ff <= period_buf_ff; // RULE4 RULE18
    end
  end

  // ========================================================
  // output pins
  // upper pins carry the phase, lower pins its complement
  // there is no dead time here: the lower pin switches in the same
  // cycle as the upper one, so any shoot-through guard sits outside
  // polarity bits should only change while the generator is off
  always_comb begin
    logic up_pol;
    logic lo_pol;
    up_pol = pwm_control_a_ff[BIT_UPPER_POL];
    lo_pol = pwm_control_a_ff[BIT_LOWER_POL];
    for (int p = 0; p < 3; p++) begin
      if (!gen_enable || pins_inhibit) begin
        // idle: every transistor off
        nxt_pins[p]   = ~up_pol; // RULE7 RULE11
        nxt_pins[p+3] = ~lo_pol;
      end else begin
        nxt_pins[p]   = phase_on[p] ? up_pol : ~up_pol; // RULE17
        nxt_pins[p+3] = phase_on[p] ? ~lo_pol : lo_pol; // RULE17
      end
    end
  end

  // registered pin drivers, inactive high after reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      {pwm_z, pwm_y, pwm_x, pwm_w, pwm_v, pwm_u} <= 6'h3F; // RULE11
    end else begin
      {pwm_z, pwm_y, pwm_x, pwm_w, pwm_v, pwm_u} <= nxt_pins;
    end
  end

  // ========================================================
  // register read port
  // read mux, answer registered for the next cycle
  // compare indexes return the buffers, not the values in use, so a
  // read right after a write shows the new value before it acts
  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      OFS_CONTROL_A:  nxt_rdata = {8'h00, pwm_control_a_ff};
      OFS_CONTROL_B:  nxt_rdata = {13'h0000, carrier_clock_select_ff};
      OFS_PERIOD:     nxt_rdata = to_bus(period_buf_ff);
      OFS_COMPARE_U:  nxt_rdata = to_bus(cmp_buf_ff[0]); // RULE8 RULE10
      OFS_COMPARE_V:  nxt_rdata = to_bus(cmp_buf_ff[1]); // RULE8 RULE10
      OFS_COMPARE_W:  nxt_rdata = to_bus(cmp_buf_ff[2]); // RULE8 RULE10
      OFS_ARITH_CTRL: nxt_rdata = {8'h00, waveform_arith_control_ff};
      OFS_STATUS: begin
        // live carrier, direction and run state
        nxt_rdata                   = to_bus(carrier_counter_ff);
        nxt_rdata[BIT_STAT_DOWN]    = count_down_ff;
        nxt_rdata[BIT_STAT_ENABLED] = gen_enable;
      end
      default:        nxt_rdata = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ### verification/three_phase_pwm_waveform_core_test.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// self-checking bench of the pwm core
module three_phase_pwm_waveform_core_test
  import tppwm_pkg::*;
;
  logic             mclk;         // clock
  logic             reset;        // sync reset
  logic [2:0]       reg_addr;     // register index
  logic [15:0]      reg_wdata;    // write data
  logic             reg_wr;       // write strobe
  logic             reg_rd;       // read strobe
  logic [15:0]      reg_rdata;    // read data
  logic             arith_valid;  // result pulse
  logic [11:0]      arith_u;      // u result
  logic [11:0]      arith_v;      // v result
  logic [11:0]      arith_w;      // w result
  wire  logic [5:0] pins;         // u v w x y z
  wire  logic [5:0] gate;         // levels at the gates
  int               n_errors;     // mismatches
  int               total_checks; // comparisons
  int               cycles;       // watchdog count
  int               cnt [6];      // low cycles per gate
  logic [15:0]      rv;           // last read value

  tppwm_core #(.CNT_W(12)) u_tppwm_core (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .arith_valid(arith_valid),
    .arith_u(arith_u), .arith_v(arith_v), .arith_w(arith_w), .pwm_u(pins[5]),
    .pwm_v(pins[4]), .pwm_w(pins[3]), .pwm_x(pins[2]), .pwm_y(pins[1]), .pwm_z(pins[0]));
  tppwm_drive_model u_tppwm_drive_model (.pwm_pins(pins), .gate_lvl(gate));

  // ========================================================
  // clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      complete_run();
    end
  end
  // ========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rv = reg_rdata;
  endtask
  task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
    rd(a);
    check(what, rv, exp);
  endtask
  task automatic pulse(input logic [11:0] u, input logic [11:0] v, input logic [11:0] w);
    @(posedge mclk);
    arith_valid <= 1'b1;
    arith_u <= u;
    arith_v <= v;
    arith_w <= w;
    @(posedge mclk);
    arith_valid <= 1'b0;
  endtask
  // count low cycles of each gate over n cycles
  task automatic count(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(negedge mclk);
      for (int i = 0; i < 6; i++) if (gate[i] === 1'b0) cnt[i]++;
    end
  endtask
  task automatic setup(input int p, input int u, input int v, input int w, input int a);
    wr(OFS_CONTROL_A, 16'h0000);
    wr(OFS_PERIOD, 16'(p));
    wr(OFS_COMPARE_U, 16'(u));
    wr(OFS_COMPARE_V, 16'(v));
    wr(OFS_COMPARE_W, 16'(w));
    wr(OFS_CONTROL_A, 16'(a));
    repeat (24) @(posedge mclk);
  endtask
  // ========================================================
  // scenarios
  task automatic t_reset();
    for (int a = 0; a < 7; a++) rd_chk("reset reg", 3'(a), 16'h0000);
    check("reset pins", {10'h000, gate}, 16'h003F);
  endtask
  task automatic t_saw();
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CONTROL_B, 16'(s));
      setup(4, 1, 2, 3, 16'h0001);
      count(32 << s);
      check("saw u", 16'(cnt[5]), 16'(8 << s));
      check("saw v", 16'(cnt[4]), 16'(16 << s));
      check("saw w", 16'(cnt[3]), 16'(24 << s));
      check("saw x", 16'(cnt[2]), 16'(24 << s));
    end
    wr(OFS_CONTROL_B, 16'h0000);
    setup(4, 1, 3, 3, 16'h0041);
    count(32);
    check("common v", 16'(cnt[4]), 16'd8);
  endtask
  task automatic t_tri();
    setup(4, 2, 4, 0, 16'h0003);
    count(64);
    check("tri u", 16'(cnt[5]), 16'd24);
    check("tri v", 16'(cnt[4]), 16'd56);
    check("tri w", 16'(cnt[3]), 16'd0);
    check("tri y", 16'(cnt[1]), 16'd8);
    check("tri z", 16'(cnt[0]), 16'd64);
  endtask
  task automatic t_polarity();
    wr(OFS_CONTROL_A, 16'h0020);
    repeat (2) @(negedge mclk);
    check("idle upper hi", {10'h000, gate}, 16'h0007);
    wr(OFS_CONTROL_A, 16'h0010);
    repeat (2) @(negedge mclk);
    check("idle lower hi", {10'h000, gate}, 16'h0038);
    setup(4, 1, 1, 1, 16'h0021);
    count(32);
    check("pol u", 16'(cnt[5]), 16'd24);
    check("pol x", 16'(cnt[2]), 16'd24);
  endtask
  task automatic t_buffer();
    setup(8, 2, 2, 2, 16'h0001);
    for (int i = 0; i < 20; i++) begin
      rd(OFS_STATUS);
      if (rv[11:0] == 12'h002 || rv[11:0] == 12'h003) break;
    end
    wr(OFS_COMPARE_U, 16'h0006);
    repeat (2) begin
      @(negedge mclk);
      check("held duty", {15'h0000, gate[5]}, 16'h0001);
    end
    repeat (16) @(posedge mclk);
    count(16);
    check("new duty", 16'(cnt[5]), 16'd12);
  endtask
  task automatic t_arith();
    setup(4, 0, 0, 0, 16'h0000);
    wr(OFS_ARITH_CTRL, 16'h0002);
    pulse(12'h005, 12'h006, 12'h007);
    rd_chk("res u", OFS_COMPARE_U, 16'h0005);
    rd_chk("res v", OFS_COMPARE_V, 16'h0006);
    rd_chk("res w", OFS_COMPARE_W, 16'h0007);
    wr(OFS_COMPARE_U, 16'h0009);
    rd_chk("sw u", OFS_COMPARE_U, 16'h0009);
    pulse(12'h123, 12'h006, 12'h007);
    rd_chk("next res", OFS_COMPARE_U, 16'h0123);
    wr(OFS_ARITH_CTRL, 16'h0006);
    wr(OFS_COMPARE_U, 16'h0456);
    rd_chk("locked u", OFS_COMPARE_U, 16'h0123);
    pulse(12'h002, 12'h002, 12'h002);
    wr(OFS_CONTROL_A, 16'h0001);
    repeat (16) @(posedge mclk);
    count(32);
    check("res duty", 16'(cnt[5]), 16'd16);
    wr(OFS_ARITH_CTRL, 16'h0012);
    repeat (4) @(posedge mclk);
    count(16);
    check("inhib u", 16'(cnt[5]), 16'd0);
    check("inhib x", 16'(cnt[2]), 16'd0);
    pulse(12'h001, 12'h001, 12'h001);
    rd_chk("inhib buf", OFS_COMPARE_U, 16'h0001);
    wr(OFS_ARITH_CTRL, 16'h0000);
  endtask
  // ========================================================
  // closing report
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    arith_valid = 1'b0;
    arith_u = 12'h000;
    arith_v = 12'h000;
    arith_w = 12'h000;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_saw();
    t_tri();
    t_polarity();
    t_buffer();
    t_arith();
    complete_run();
  end
endmodule
`default_nettype wire

// ### verification/tppwm_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// port checks of the pwm core
module tppwm_core_checker
  import tppwm_pkg::*;
#(
  parameter int CNT_W = 12 // carrier width
) (
  input wire logic             mclk,        // clock
  input wire logic             reset,       // sync reset
  input wire logic [2:0]       reg_addr,    // register index
  input wire logic [15:0]      reg_wdata,   // write data
  input wire logic             reg_wr,      // write strobe
  input wire logic             reg_rd,      // read strobe
  input wire logic [15:0]      reg_rdata,   // read data
  input wire logic             arith_valid, // result pulse
  input wire logic [CNT_W-1:0] arith_u,     // u result
  input wire logic [CNT_W-1:0] arith_v,     // v result
  input wire logic [CNT_W-1:0] arith_w,     // w result
  input wire logic             pwm_u,       // upper u
  input wire logic             pwm_v,       // upper v
  input wire logic             pwm_w,       // upper w
  input wire logic             pwm_x,       // lower u
  input wire logic             pwm_y,       // lower v
  input wire logic             pwm_z        // lower w
);
  // ========================================================
  // shadows of what software wrote
  logic [7:0]       ctl_ff;   // control a copy
  logic [7:0]       ari_ff;   // arith control copy
  logic [CNT_W-1:0] cu_ff;    // u compare buffer copy
  logic [5:0]       pins;     // all six outputs
  logic [5:0]       idle_lvl; // inactive level of each pin
  logic             lock;     // compare writes blocked
  assign pins = {pwm_u, pwm_v, pwm_w, pwm_x, pwm_y, pwm_z};
  assign idle_lvl = {{3{~ctl_ff[BIT_UPPER_POL]}}, {3{~ctl_ff[BIT_LOWER_POL]}}};
  assign lock = ari_ff[BIT_CALC_ENABLE] & ari_ff[BIT_XFER_ENABLE];
  // follow control writes
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctl_ff <= RST_CONTROL_A;
      ari_ff <= RST_ARITH_CTRL;
    end else if (reg_wr && reg_addr == OFS_CONTROL_A) begin
      ctl_ff <= reg_wdata[7:0];
    end else if (reg_wr && reg_addr == OFS_ARITH_CTRL) begin
      ari_ff <= reg_wdata[7:0];
    end
  end
  // follow the u buffer, a result beats a write
  always_ff @(posedge mclk) begin
    if (reset) begin
      cu_ff <= '0;
    end else if (arith_valid && ari_ff[BIT_CALC_ENABLE]) begin
      cu_ff <= arith_u;
    end else if (reg_wr && reg_addr == OFS_COMPARE_U && !lock) begin
      cu_ff <= reg_wdata[CNT_W-1:0];
    end
  end
  // ========================================================
  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_reset_idle: assert property (
    $fell(reset) |-> pins == 6'h3F && reg_rdata == 16'h0000)
    else $error("outputs not idle after reset");
  a_rdata_pulse: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_idle_off: assert property (
    !ctl_ff[BIT_GEN_ENABLE] |=> pins == $past(idle_lvl))
    else $error("pins active while disabled");
  a_inhibit_off: assert property (
    ari_ff[BIT_CALC_ENABLE] && ari_ff[BIT_XFER_INHIBIT] |=> pins == $past(idle_lvl))
    else $error("pins active while inhibited");
  a_phase_excl: assert property (
    ctl_ff[BIT_GEN_ENABLE] |=> !(pins[5] != $past(idle_lvl[5])
                                 && pins[2] != $past(idle_lvl[2])))
    else $error("upper and lower both active");
  a_compare_read: assert property (
    reg_rd && reg_addr == OFS_COMPARE_U |=> reg_rdata == 16'($past(cu_ff)))
    else $error("u compare read wrong");
  a_lock_write: assert property (
    (reg_wr && reg_addr == OFS_COMPARE_U && lock && !arith_valid) ##1
    (!reg_wr && !arith_valid) ##1
    (reg_rd && reg_addr == OFS_COMPARE_U) |=> reg_rdata == 16'($past(cu_ff, 3)))
    else $error("locked compare was written");
  a_arith_load: assert property (
    (arith_valid && ari_ff[BIT_CALC_ENABLE]) ##1
    (!arith_valid && !reg_wr) ##1
    (reg_rd && reg_addr == OFS_COMPARE_U && !arith_valid)
    |=> reg_rdata[CNT_W-1:0] == $past(arith_u, 3))
    else $error("result not in u buffer");
endmodule
bind tppwm_core tppwm_core_checker #(.CNT_W(CNT_W)) u_tppwm_core_checker (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .arith_valid(arith_valid), .arith_u(arith_u), .arith_v(arith_v), .arith_w(arith_w),
  .pwm_u(pwm_u), .pwm_v(pwm_v), .pwm_w(pwm_w), .pwm_x(pwm_x), .pwm_y(pwm_y), .pwm_z(pwm_z));
`default_nettype wire

// ### verification/tppwm_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// power stage seen through the output port of the device
module tppwm_drive_model #(
  parameter logic PORT_DATA = 1'b1, // port_output_data bit
  parameter logic PORT_CTRL = 1'b1  // port_output_control bit
) (
  input  wire logic [5:0] pwm_pins, // u v w x y z from the core
  output logic      [5:0] gate_lvl  // level at the transistor gates
);
  // pins reach the gates only with both port bits set, else pulled off
  assign gate_lvl = (PORT_DATA && PORT_CTRL) ? pwm_pins : 6'h3F;
endmodule
`default_nettype wire
